// ---- pkg/pcni_pkg.sv ----
// package: constants and carrier types for the pin change notify block
`default_nettype none
package pcni_pkg;
  // ==========================================================
  // sizes and field positions
  localparam int          PCNI_PINS       = 22;     // change inputs
  localparam int          PCNI_CTL_ON_BIT = 15;     // module on
  localparam int          PCNI_CTL_FRZ    = 14;     // debug freeze
  localparam int          PCNI_CTL_STOP_IN_IDLE   = 13;     // stop in idle
  localparam int          PCNI_PRI_LSB    = 18;     // priority field lsb
  localparam int          PCNI_SUB_LSB    = 16;     // subpriority lsb
  localparam int          PCNI_FLAG_BIT   = 0;      // flag/enable bit
  localparam logic [5:0]  PCNI_VECTOR     = 6'h17;  // vector/irq 23
  localparam logic [2:0]  PCNI_PRI_OFF    = 3'h0;   // no interrupt
  localparam logic [2:0]  PCNI_PRI_MAX    = 3'h7;   // highest group
  localparam logic [1:0]  PCNI_SUB_MAX    = 2'h3;   // highest sub
  // ==========================================================
  // reset values
  localparam logic [15:0] PCNI_CTL_RST    = 16'h0000;
  localparam logic [21:0] PCNI_EN_RST     = 22'h000000;

  // cpu power and halt state as seen by the block
  typedef struct packed {
    logic       sleep;        // system clock stopped
    logic       idle;         // cpu idle
    logic       debugHalt;    // application halted in debug
    logic [2:0] cpuPriority;  // current cpu priority
    logic       inService;    // some interrupt in service
    logic [2:0] svcPriority;  // group of the one in service
    logic [1:0] svcSub;       // its subpriority
    logic [5:0] svcVector;    // its vector number
  } pcni_cpu_s;

  // a competing request at the interrupt controller
  typedef struct packed {
    logic       valid;
    logic [2:0] prio;         // group of the competing source
    logic [1:0] sub;
    logic [5:0] vector;
  } pcni_req_s;
endpackage : pcni_pkg
`default_nettype wire

// ---- design/pcni_sync.sv ----
// two-flop synchroniser for a vector of pins, held in debug freeze
`default_nettype none
module pcni_sync #(
  parameter int W = 22
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // control
  input  wire logic         hold,     // freeze, keep state
  // data
  input  wire logic [W-1:0] pinsIn,
  output logic      [W-1:0] pinsSync
);
  // ==========================================================
  // two stages, first read only by second
  logic [W-1:0] stageA_reg;  // first stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stageA_reg <= '0;
      pinsSync   <= '0;
    end else if (!hold) begin
      stageA_reg <= pinsIn;
      pinsSync   <= stageA_reg;
    end
  end
endmodule : pcni_sync
`default_nettype wire

// ---- design/pcni_notify.sv ----
// pin change notification: mismatch detect, flag, request, wake
// How it works
// - enable clear: flag sets, no request
// - enable set: flag requests, by priority
// - priority 7 highest, 0 gives no interrupt
// - higher group preempts one in service
// - higher subpriority preempts in same group
// - tie with a competing request: lower vector number wins
// - loser stays pending, retried every cycle
// - vector and irq number are 23
// - enable bit n serves pin n, pull-ups
// - priority bits 20:18, subpriority 17:16
// - sleep: detection runs, sets flag bit
// - wake only if enabled, priority above cpu
// - priority not above cpu: no wake, idle
// - idle: stop-in-idle skips the extra stage after the synchroniser
// - debug freeze holds all state but rawHold_reg
// - device or power-on reset clears registers
// - watchdog reset leaves registers unchanged
// - mismatch versus value at last read
// - mismatches ORed, sampled every cycle
// - on bit 15 gates detection
`default_nettype none
module pcni_notify #(
  parameter int PINS = 22
) (
  // clock and resets
  input  wire logic                clock,
  input  wire logic                resetn,        // device/power-on
  input  wire logic                watchdogReset, // soft, keeps regs
  // pins
  input  wire logic [PINS-1:0]     pinsIn,        // raw pin levels
  output logic      [PINS-1:0]     pullupOn,      // pull-up drive
  // register writes
  input  wire logic                controlWr,
  input  wire logic [15:0]         controlData,
  input  wire logic                pinEnableWr,
  input  wire logic [PINS-1:0]     pinEnableData,
  input  wire logic                pullupWr,
  input  wire logic [PINS-1:0]     pullupData,
  input  wire logic                prioWr,
  input  wire logic [31:0]         prioData,      // priority register
  input  wire logic                irqEnableWr,
  input  wire logic                irqEnableData,
  input  wire logic                flagClear,     // software clear
  // port read strobe, one bit per pin (its port was read)
  input  wire logic [PINS-1:0]     portRead,
  // cpu and competing request
  input  wire pcni_pkg::pcni_cpu_s cpu,
  input  wire pcni_pkg::pcni_req_s other,
  // status and request outputs
  output logic [15:0]              changeControlReg,
  output logic [PINS-1:0]          changePinEnableReg,
  output logic [PINS-1:0]          lastReadValue,
  output logic                     changeEventFlag,
  output logic                     changeIrqEnable,
  output logic [2:0]               changeIrqPriority,
  output logic [1:0]               changeIrqSubpriority,
  output logic                     irqRequest,    // to cpu
  output logic [5:0]               irqVector,     // vector taken
  output logic                     wakeRequest,   // leave sleep/idle
  output logic                     enterIdle      // sleep becomes idle
);
  import pcni_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0]     ctl;
    logic [PINS-1:0] pinEn;
    logic [PINS-1:0] pullEn;
    logic [PINS-1:0] lastRead;
    logic [2:0]      pri;
    logic [1:0]      sub;
    logic            irqEn;
    logic            flag;
    logic            req;
    logic [5:0]      vec;
    logic            wake;
    logic            toIdle;
  } pcni_state_s;

  pcni_state_s st_reg;   // registered state
  pcni_state_s st_next;  // next state

  // ==========================================================
  // control decode
  logic            modOn;    // logic enabled
  logic            frozen;   // debug freeze active
  logic            bypass;   // idle without the extra stage
  logic [PINS-1:0] syncPins; // synchronised pins
  logic [PINS-1:0] pinsSeen; // pins the comparator sees
  logic [PINS-1:0] mismatch; // per pin mismatch
  logic            anyChange;
  logic            pending;  // flag asks for interrupt
  logic            beatsSvc; // may preempt the one in service
  logic            beatsReq; // wins against the other request

  assign modOn  = st_reg.ctl[PCNI_CTL_ON_BIT];
  assign frozen = st_reg.ctl[PCNI_CTL_FRZ] & cpu.debugHalt;
  assign bypass = st_reg.ctl[PCNI_CTL_STOP_IN_IDLE] & cpu.idle;

  // synchroniser stays running unless frozen
  pcni_sync #(
    .W (PINS)
  ) u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .hold     (frozen),
    .pinsIn   (pinsIn),
    .pinsSync (syncPins)
  );

  // second stage only; first stage never read here
  logic [PINS-1:0] rawHold_reg;  // extra stage, skipped when bypassed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rawHold_reg <= '0;
    end else begin
      rawHold_reg <= syncPins;
    end
  end

  // idle with stop-in-idle: take the later synchronised sample
  // directly, without waiting for the extra stage
  assign pinsSeen = bypass ? syncPins : rawHold_reg;

  // ==========================================================
  // per pin compare against value at last read
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : gen_cmp
      assign mismatch[g] = modOn & st_reg.pinEn[g]
                         & (pinsSeen[g] ^ st_reg.lastRead[g]);
    end
  endgenerate

  assign anyChange = |mismatch;

  // ==========================================================
  // arbitration against service and competing source
  assign pending = st_reg.flag & st_reg.irqEn
                 & (st_reg.pri != PCNI_PRI_OFF);

  always_comb begin
    // preemption of the interrupt in service
    if (!cpu.inService) begin
      beatsSvc = 1'b1;
    end else if (st_reg.pri != cpu.svcPriority) begin
      beatsSvc = st_reg.pri > cpu.svcPriority;
    end else if (st_reg.sub != cpu.svcSub) begin
      beatsSvc = st_reg.sub > cpu.svcSub;
    end else begin
      beatsSvc = 1'b0;
    end
    // against another simultaneous request
    if (!other.valid) begin
      beatsReq = 1'b1;
    end else if (st_reg.pri != other.prio) begin
      beatsReq = st_reg.pri > other.prio;
    end else if (st_reg.sub != other.sub) begin
      beatsReq = st_reg.sub > other.sub;
    end else begin
      beatsReq = PCNI_VECTOR < other.vector;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    if (!frozen) begin
      // register writes
      if (controlWr) begin
        st_next.ctl = controlData;
      end
      if (pinEnableWr) begin
        st_next.pinEn = pinEnableData;
      end
      if (pullupWr) begin
        st_next.pullEn = pullupData;
      end
      if (prioWr) begin
        st_next.pri = prioData[PCNI_PRI_LSB +: 3];
        st_next.sub = prioData[PCNI_SUB_LSB +: 2];
      end
      if (irqEnableWr) begin
        st_next.irqEn = irqEnableData;
      end
      // a read captures the current pin value, ending mismatch
      for (int i = 0; i < PINS; i++) begin
        if (portRead[i]) begin
          st_next.lastRead[i] = pinsSeen[i];
        end
      end
      // flag: set wins over clear; hardware never self-clears
      if (anyChange) begin
        st_next.flag = 1'b1;
      end else if (flagClear) begin
        st_next.flag = 1'b0;
      end
      // request held while pending and winning, else retried
      st_next.req = pending & beatsSvc & beatsReq;
      st_next.vec = PCNI_VECTOR;
      // wake decision in sleep or idle
      if (cpu.sleep | cpu.idle) begin
        st_next.wake   = pending & (st_reg.pri > cpu.cpuPriority);
        st_next.toIdle = cpu.sleep & pending
                       & (st_reg.pri <= cpu.cpuPriority);
      end else begin
        st_next.wake   = 1'b0;
        st_next.toIdle = 1'b0;
      end
    end
  end

  // ==========================================================
  // state register; watchdog reset keeps registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg          <= '0;
      st_reg.ctl      <= PCNI_CTL_RST;
      st_reg.pinEn    <= PCNI_EN_RST;
      st_reg.pullEn   <= PCNI_EN_RST;
      st_reg.vec      <= PCNI_VECTOR;
    end else if (watchdogReset) begin
      st_reg.req    <= 1'b0;
      st_reg.wake   <= 1'b0;
      st_reg.toIdle <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign pullupOn             = st_reg.pullEn;
  assign changeControlReg     = st_reg.ctl;
  assign changePinEnableReg   = st_reg.pinEn;
  assign lastReadValue        = st_reg.lastRead;
  assign changeEventFlag      = st_reg.flag;
  assign changeIrqEnable      = st_reg.irqEn;
  assign changeIrqPriority    = st_reg.pri;
  assign changeIrqSubpriority = st_reg.sub;
  assign irqRequest           = st_reg.req;
  assign irqVector            = st_reg.vec;
  assign wakeRequest          = st_reg.wake;
  assign enterIdle            = st_reg.toIdle;
endmodule : pcni_notify
`default_nettype wire

// ---- bench/pcni_monitor.sv ----
// checker: port relations of the pin change notify block
`default_nettype none
module pcni_monitor #(
  parameter int PINS = 22
) (
  // clock and resets
  input wire logic                clock,
  input wire logic                resetn,
  input wire logic                watchdogReset,
  // strobes and cpu state
  input wire logic                controlWr,
  input wire logic                pinEnableWr,
  input wire logic [PINS-1:0]     pinEnableData,
  input wire logic                flagClear,
  input wire pcni_pkg::pcni_cpu_s cpu,
  // outputs watched
  input wire logic [15:0]         changeControlReg,
  input wire logic [PINS-1:0]     changePinEnableReg,
  input wire logic                changeEventFlag,
  input wire logic                changeIrqEnable,
  input wire logic [2:0]          changeIrqPriority,
  input wire logic                irqRequest,
  input wire logic [5:0]          irqVector,
  input wire logic                wakeRequest,
  input wire logic                enterIdle
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcni_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic debug_freeze = cpu.debugHalt & changeControlReg[PCNI_CTL_FRZ]; // frozen
  a_no_req_off:
    assert property (!changeIrqEnable && !$past(changeIrqEnable)
      |-> !irqRequest) else $error("request while disabled");
  a_prio_zero_quiet:
    assert property (changeIrqPriority == PCNI_PRI_OFF &&
      $past(changeIrqPriority) == PCNI_PRI_OFF |-> !irqRequest)
      else $error("request at priority zero");
  a_vector_fixed:
    assert property (irqRequest |-> irqVector == PCNI_VECTOR)
      else $error("wrong vector");
  a_flag_held:
    assert property (changeEventFlag && !flagClear |=> changeEventFlag)
      else $error("flag dropped");
  a_on_gates:
    assert property ($rose(changeEventFlag)
      |-> $past(changeControlReg[PCNI_CTL_ON_BIT]))
      else $error("flag while off");
  a_freeze_holds:
    assert property (debug_freeze |=> $stable(changePinEnableReg) &&
      $stable(changeEventFlag)) else $error("state moved while frozen");
  a_wdog_keeps:
    assert property (watchdogReset && !controlWr && !pinEnableWr
      |=> $stable(changeControlReg) && $stable(changePinEnableReg) &&
      !irqRequest && !wakeRequest) else $error("watchdog changed state");
  a_enable_write:
    assert property (pinEnableWr && !debug_freeze && !watchdogReset
      |=> changePinEnableReg == $past(pinEnableData))
      else $error("enable write lost");
  a_wake_prio:
    assert property (wakeRequest |-> $past(changeIrqEnable) &&
      $past(changeIrqPriority) > $past(cpu.cpuPriority))
      else $error("wake without priority");
  a_idle_prio:
    assert property (enterIdle |->
      $past(changeIrqPriority) <= $past(cpu.cpuPriority))
      else $error("idle with high priority");
  c_req: cover property (irqRequest);
  c_wake: cover property (wakeRequest);
  c_idle: cover property (enterIdle);
endmodule : pcni_monitor
bind pcni_notify pcni_monitor #(.PINS(PINS)) u_mon (.*);
`default_nettype wire

// ---- bench/pcni_isr_model.sv ----
// partner: service routine that reads ports then clears the flag
`default_nettype none
module pcni_isr_model (
  // clock and control
  input wire logic                         clock,
  input wire logic                         on,
  input wire logic                         irqRequest,
  // service actions
  output logic [pcni_pkg::PCNI_PINS-1:0]   portRead,
  output logic                             flagClear
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcni_pkg::*;
  // take each request: read all ports first, clear the flag after
  initial begin
    portRead = '0;
    flagClear = 1'b0;
    forever begin
      @(negedge clock);
      if (on && irqRequest === 1'b1) begin
        repeat (2) @(negedge clock);
        portRead = '1;
        @(negedge clock);
        portRead = '0;
        flagClear = 1'b1;
        @(negedge clock);
        flagClear = 1'b0;
      end
    end
  end
endmodule : pcni_isr_model
`default_nettype wire

// ---- bench/testbench.sv ----
// testbench: directed sequences for the pin change notify block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcni_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clock = 0, resetn = 0, watchdogReset = 0, svcOn = 0;
  logic [21:0] pinsIn = '0, pinEnableData = '0, pullupData = '0;
  logic [21:0] tbRead = '0, pullupOn, changePinEnableReg, lastReadValue;
  logic [21:0] mRead;
  logic [15:0] controlData = '0, changeControlReg;
  logic [31:0] prioData = '0;
  logic controlWr = 0, pinEnableWr = 0, pullupWr = 0, prioWr = 0;
  logic irqEnableWr = 0, irqEnableData = 0, tbClr = 0, mClr;
  logic changeEventFlag, changeIrqEnable, irqRequest, wakeRequest;
  logic enterIdle;
  logic [2:0] changeIrqPriority;
  logic [1:0] changeIrqSubpriority;
  logic [5:0] irqVector;
  pcni_cpu_s cpu = '0;
  pcni_req_s other = '0;
  int n_errors = 0, total_checks = 0, cyc = 0;
  wire logic [21:0] portRead = tbRead | mRead;
  wire logic flagClear = tbClr | mClr;
  // arbitration cases: {expect, otherValid, inService, pri, sub}
  logic [7:0] tab [5] = '{8'hAC, 8'hB6, 8'h37, 8'h57, 8'h80};
  pcni_notify i_dut (.*);
  pcni_isr_model i_isr (.clock(clock), .on(svcOn), .irqRequest(irqRequest),
    .portRead(mRead), .flagClear(mClr));
  initial forever #12.5 clock = ~clock;
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      complete_run();
    end
  end
  // ==========================================================
  // access tasks; k: 0 ctl 1 enable 2 pullup 3 prio 4 irq 5 clr 6 read
  task automatic wr(input int k, input logic [31:0] d);
    @(negedge clock);
    case (k)
      0: {controlWr, controlData} = {1'b1, d[15:0]};
      1: {pinEnableWr, pinEnableData} = {1'b1, d[21:0]};
      2: {pullupWr, pullupData} = {1'b1, d[21:0]};
      3: {prioWr, prioData} = {1'b1, d};
      4: {irqEnableWr, irqEnableData} = {1'b1, d[0]};
      5: tbClr = 1'b1;
      default: tbRead = d[21:0];
    endcase
    @(negedge clock);
    {controlWr, pinEnableWr, pullupWr, prioWr, irqEnableWr, tbClr} = '0;
    tbRead = '0;
  endtask : wr
  task automatic tog(input logic [21:0] m);
    @(negedge clock);
    pinsIn ^= m;
    repeat (8) @(negedge clock);
  endtask : tog
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(negedge clock);
    resetn = 1;
    chk("ctl", PCNI_CTL_RST, changeControlReg);
    chk("en", PCNI_EN_RST, changePinEnableReg);
    chk("vector", PCNI_VECTOR, irqVector);
    wr(0, 32'h8000);
    wr(1, 32'h040012);
    wr(2, 32'h040012);
    wr(3, 32'h00170000);
    chk("pullup", 22'h040012, pullupOn);
    chk("prio", 5'h17, {changeIrqPriority, changeIrqSubpriority});
    wr(6, 32'h3FFFFF);
    tog(22'h000001);
    chk("flag pin0", 0, changeEventFlag);
    tog(22'h000010);
    chk("flag pin4", 1, changeEventFlag);
    chk("req ie0", 0, irqRequest);
    wr(4, 1);
    chk("flag held", 1, changeEventFlag);
    @(negedge clock);
    chk("req ie1", 1, irqRequest);
    foreach (tab[i]) begin
      @(negedge clock);
      cpu.inService = tab[i][5];
      {cpu.svcPriority, cpu.svcSub} = tab[i][4:0];
      other = '{tab[i][6], tab[i][4:2], tab[i][1:0], 6'h0A};
      repeat (3) @(negedge clock);
      chk("arbit", tab[i][7], irqRequest);
    end
    svcOn = 1;
    tog(22'h040000);
    repeat (8) @(negedge clock);
    svcOn = 0;
    chk("flag svc", 0, changeEventFlag);
    chk("last read", 22'h040011, lastReadValue);
    wr(3, 0);
    tog(22'h000002);
    chk("flag p0", 1, changeEventFlag);
    chk("req p0", 0, irqRequest);
    wr(6, 32'h3FFFFF);
    wr(5, 0);
    wr(0, 0);
    tog(22'h000002);
    chk("flag off", 0, changeEventFlag);
    wr(0, 32'hC000);
    cpu.debugHalt = 1;
    wr(1, 0);
    chk("frozen en", 22'h040012, changePinEnableReg);
    cpu.debugHalt = 0;
    watchdogReset = 1;
    repeat (2) @(negedge clock);
    watchdogReset = 0;
    chk("wdog ctl", 16'hC000, changeControlReg);
    wr(3, 32'h00170000);
    {cpu.sleep, cpu.cpuPriority} = {1'b1, 3'h2};
    tog(22'h000010);
    chk("wake", 1, wakeRequest);
    wr(6, 32'h3FFFFF);
    wr(5, 0);
    cpu.cpuPriority = 3'h6;
    tog(22'h000010);
    chk("no wake", 0, wakeRequest);
    chk("idle", 1, enterIdle);
    {cpu.sleep, cpu.idle} = 2'b01;
    wr(6, 32'h3FFFFF);
    wr(5, 0);
    wr(0, 32'hA000);
    tog(22'h000010);
    chk("flag idle", 1, changeEventFlag);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
